// ---- src/csfs_defines.vh ----
// Constants for the contact-stop frequency selection block
`ifndef CSFS_DEFINES_VH
`define CSFS_DEFINES_VH

// ==========================================================
// Register byte offsets
`define CSFS_OFS_ENABLE      8'h00
`define CSFS_OFS_MODE        8'h04
`define CSFS_OFS_SUPPR       8'h08
`define CSFS_OFS_PRM_FIRST   8'h0c
`define CSFS_OFS_PRM_LAST    8'h3c
`define CSFS_OFS_TERM_LO     8'h40
`define CSFS_OFS_TERM_HI     8'h44
`define CSFS_OFS_STATUS      8'h48

// ==========================================================
// Parameter array indices (offset = 0x0c + 4 * index)
`define CSFS_PRM_HIGH        4'd0
`define CSFS_PRM_MID         4'd1
`define CSFS_PRM_LOW         4'd2
`define CSFS_PRM_SP4         4'd3
`define CSFS_PRM_SP5         4'd4
`define CSFS_PRM_SP6         4'd5
`define CSFS_PRM_SP7         4'd6
`define CSFS_PRM_INCH        4'd7
`define CSFS_PRM_STALL       4'd8
`define CSFS_PRM_STALL2      4'd9
`define CSFS_PRM_CARRIER     4'd10
`define CSFS_PRM_CS_CARRIER  4'd11
`define CSFS_PRM_EXCIT       4'd12
`define CSFS_PRM_COUNT       13

// ==========================================================
// Field positions
`define CSFS_MODE_OP_LSB     0
`define CSFS_MODE_CTRL_LSB   8
`define CSFS_SUPPR_REM_LSB   0
`define CSFS_SUPPR_PID_LSB   8
`define CSFS_SUPPR_AUTO_LSB  16

// ==========================================================
// Reset values
`define CSFS_RST_ENABLE      8'h00
`define CSFS_RST_MODE_OP     8'h00
`define CSFS_RST_MODE_CTRL   8'h00
`define CSFS_RST_SUPPR       8'h00
`define CSFS_RST_PRM         16'h0000
`define CSFS_RST_TERM        8'hff

// ==========================================================
// Codes and limits (frequencies in 0.01 Hz, levels in 0.1 %)
`define CSFS_ENABLE_ON       8'h01
`define CSFS_OP_EXTERNAL     8'h00
`define CSFS_CTRL_ADV_FLUX   8'h01
`define CSFS_CTRL_GP_FLUX    8'h02
`define CSFS_REM_MIN         8'h01
`define CSFS_REM_MAX         8'h03
`define CSFS_NOT_SET         16'h270f
`define CSFS_LOW_CLAMP       16'h0bb8
`define CSFS_CARRIER_FREQ    16'h012c
`define CSFS_EXCIT_MAX       16'h012c
`define CSFS_FN_LOW          8'h00
`define CSFS_FN_MID          8'h01
`define CSFS_FN_HIGH         8'h02
`define CSFS_FN_SECOND       8'h03
`define CSFS_FN_INCH         8'h05

// ==========================================================
// Frequency source select codes
`define CSFS_SEL_ANALOG      4'd0
`define CSFS_SEL_HIGH        4'd1
`define CSFS_SEL_MID         4'd2
`define CSFS_SEL_LOW         4'd3
`define CSFS_SEL_SP4         4'd4
`define CSFS_SEL_SP5         4'd5
`define CSFS_SEL_SP6         4'd6
`define CSFS_SEL_SP7         4'd7
`define CSFS_SEL_INCH        4'd8

`endif

// ---- src/csfs_pin_sync.v ----
// Three-stage synchroniser with agreement filter for terminal pins
`timescale 1ns/10ps
`default_nettype none
module csfs_pin_sync #(
  parameter W = 7
) (
  // Clock and reset
  input  wire         ref_clk_i,
  input  wire         rst_n_i,
  // Pins in, filtered levels out
  input  wire [W-1:0] pin_i,
  output reg  [W-1:0] level_o
);
  reg [W-1:0] s1_q;
  reg [W-1:0] s2_q;
  reg [W-1:0] s3_q;

  // ==========================================================
  // Level changes only when stages two and three agree
  always @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      s1_q    <= {W{1'b0}};
      s2_q    <= {W{1'b0}};
      s3_q    <= {W{1'b0}};
      level_o <= {W{1'b0}};
    end else begin
      s1_q    <= pin_i;
      s2_q    <= s1_q;
      s3_q    <= s2_q;
      level_o <= (s2_q & s3_q) | (level_o & (s2_q | s3_q));
    end
  end
endmodule // csfs_pin_sync
`default_nettype wire

// ---- src/csfs_freq_select.v ----
// Priority table for the frequency source and contact-stop decision
`timescale 1ns/10ps
`default_nettype none
`include "csfs_defines.vh"
module csfs_freq_select (
  // Function levels
  input  wire       high_i,
  input  wire       mid_i,
  input  wire       low_i,
  input  wire       second_i,
  input  wire       inch_i,
  // Qualifiers
  input  wire       cs_enabled_i,
  input  wire       cs_allowed_i,
  // Decision
  output reg  [3:0] sel_o,
  output wire       cs_active_o
);
  // Inching always wins, so it also ends contact-stop
  assign cs_active_o = cs_enabled_i & cs_allowed_i & low_i & second_i & ~inch_i;

  always @* begin
    if (inch_i) begin
      sel_o = `CSFS_SEL_INCH;
    end else if (cs_active_o) begin
      sel_o = `CSFS_SEL_LOW;
    end else begin
      // Second function does not alter the multi-speed choice
      case ({high_i, mid_i, low_i})
        3'b100:  sel_o = `CSFS_SEL_HIGH;
        3'b010:  sel_o = `CSFS_SEL_MID;
        3'b001:  sel_o = `CSFS_SEL_LOW;
        3'b110:  sel_o = `CSFS_SEL_SP6;
        3'b101:  sel_o = `CSFS_SEL_SP5;
        3'b011:  sel_o = `CSFS_SEL_SP4;
        3'b111:  sel_o = `CSFS_SEL_SP7;
        default: sel_o = `CSFS_SEL_ANALOG;
      endcase
    end
  end
endmodule // csfs_freq_select
`default_nettype wire

// ---- src/csfs_top.v ----
// Contact-stop frequency selection with APB parameter registers
// Summary of operation
// - Contact-stop only when the enable parameter equals 1, else normal selection.
// - Contact-stop needs external mode and one of two flux-vector methods.
// - Second-function plus low-speed inputs enter contact-stop at low-speed frequency.
// - Low-speed command clamped to 30 Hz during contact-stop.
// - Either of the two inputs off means normal operation.
// - Second function comes from terminals coded 3, low speed from code 0.
// - Panel, panel-plus-external, inching, PID and auto accel suppress contact-stop.
// - Remote setting selection of 1 to 3 suppresses contact-stop.
// - Contact-stop uses second stall level; 9999 falls back to normal level.
// - Contact carrier at or below 3 Hz unless its parameter is 9999.
// - Excitation compensation, 0 to 300 percent, applies only in contact-stop.
// - Inching input selects inching frequency over all other inputs.
// - Without inching, qualified contact-stop (low plus second) selects low speed over high and middle.
// - Second function alone selects analog; otherwise multi-speed choice unchanged.
// - Single inputs pick their speed; pairs pick speeds 6, 5, 4; all three speed 7.
// - Middle alone selects middle; no input selects the analog frequency.
//
// Register access over APB and the register offsets were decided locally.
`timescale 1ns/10ps
`default_nettype none
`include "csfs_defines.vh"
module csfs_top #(
  parameter NUM_TERM = 7,
  parameter AW       = 8
) (
  // Clock and reset
  input  wire                ref_clk_i,
  input  wire                rst_n_i,
  // APB slave
  input  wire                psel,
  input  wire                penable,
  input  wire                pwrite,
  input  wire [AW-1:0]       paddr,
  input  wire [31:0]         pwdata,
  output wire                pready,
  output reg  [31:0]         prdata,
  output reg                 pslverr,
  // Terminal pins and drive-core feedback
  input  wire [NUM_TERM-1:0] term_pin_i,
  input  wire [15:0]         analog_freq_i,
  input  wire [15:0]         output_freq_i,
  // Commands to the drive core
  output reg  [15:0]         freq_cmd_o,
  output reg  [3:0]          freq_src_o,
  output reg                 contact_stop_active_o,
  output reg  [15:0]         stall_level_o,
  output reg  [15:0]         carrier_o,
  output reg  [15:0]         excit_comp_o,
  output reg                 excit_comp_en_o,
  output reg                 fast_current_limit_en_o
);
  // ==========================================================
  // Parameter storage
  reg  [7:0]  contact_stop_enable_param_q;
  reg  [7:0]  operation_mode_param_q;
  // Control method shares the mode word with operation mode
  reg  [7:0]  control_method_q;
  reg  [7:0]  remote_setting_select_param_q;
  reg  [7:0]  pid_action_param_q;
  reg  [7:0]  auto_accel_decel_param_q;
  reg  [15:0] prm_q [0:`CSFS_PRM_COUNT-1];
  // Codes reset to no function, so no pin acts before setup
  reg  [7:0]  term_fn_q [0:NUM_TERM-1];

  wire [NUM_TERM-1:0] term_lvl;
  wire                sel_cs_active;
  wire [3:0]          sel_src;
  integer             i;

  // ==========================================================
  // Terminal synchronisation and function routing
  // Four flops per pin stop a bouncing switch from toggling the table
  csfs_pin_sync #(
    .W (NUM_TERM)
  ) u_sync (
    .ref_clk_i (ref_clk_i),
    .rst_n_i   (rst_n_i),
    .pin_i     (term_pin_i),
    .level_o   (term_lvl)
  );

  wire [NUM_TERM-1:0] hit_low;
  wire [NUM_TERM-1:0] hit_mid;
  wire [NUM_TERM-1:0] hit_high;
  wire [NUM_TERM-1:0] hit_second;
  wire [NUM_TERM-1:0] hit_inch;

  // Codes matching no function leave the terminal idle
  genvar g;
  generate
    for (g = 0; g < NUM_TERM; g = g + 1) begin : g_term
      assign hit_low[g]    = term_lvl[g] & (term_fn_q[g] == `CSFS_FN_LOW);
      assign hit_second[g] = term_lvl[g] & (term_fn_q[g] == `CSFS_FN_SECOND);
      assign hit_mid[g]    = term_lvl[g] & (term_fn_q[g] == `CSFS_FN_MID);
      assign hit_high[g]   = term_lvl[g] & (term_fn_q[g] == `CSFS_FN_HIGH);
      assign hit_inch[g]   = term_lvl[g] & (term_fn_q[g] == `CSFS_FN_INCH);
    end
  endgenerate

  // A function is on if any terminal with its code is high
  wire low_speed_select_input       = |hit_low;
  wire second_function_select_input = |hit_second;
  wire middle_speed_select_input    = |hit_mid;
  wire high_speed_select_input      = |hit_high;
  wire inching_input                = |hit_inch;

  // ==========================================================
  // Qualification of contact-stop
  // Any value but exactly one keeps normal selection
  wire cs_enabled  = (contact_stop_enable_param_q == `CSFS_ENABLE_ON);
  wire op_external = (operation_mode_param_q == `CSFS_OP_EXTERNAL);
  wire ctrl_adv    = (control_method_q == `CSFS_CTRL_ADV_FLUX);
  wire ctrl_gp     = (control_method_q == `CSFS_CTRL_GP_FLUX);
  wire mode_ok     = op_external && (ctrl_adv || ctrl_gp);
  wire remote_on   = (remote_setting_select_param_q >= `CSFS_REM_MIN) &&
                     (remote_setting_select_param_q <= `CSFS_REM_MAX);
  wire pid_on      = (pid_action_param_q != 8'h00);
  wire auto_on     = (auto_accel_decel_param_q != 8'h00);
  // Inching is left to the table, where it also wins
  wire cs_allowed  = mode_ok && !remote_on && !pid_on && !auto_on;

  csfs_freq_select u_sel (
    .high_i       (high_speed_select_input),
    .mid_i        (middle_speed_select_input),
    .low_i        (low_speed_select_input),
    .second_i     (second_function_select_input),
    .inch_i       (inching_input),
    .cs_enabled_i (cs_enabled),
    .cs_allowed_i (cs_allowed),
    .sel_o        (sel_src),
    .cs_active_o  (sel_cs_active)
  );

  // ==========================================================
  // Command values
  // A parameter write reaches the outputs one edge after it lands
  reg  [15:0] freq_d;
  wire [15:0] low_prm = prm_q[`CSFS_PRM_LOW];

  always @* begin
    case (sel_src)
      `CSFS_SEL_HIGH: freq_d = prm_q[`CSFS_PRM_HIGH];
      `CSFS_SEL_MID:  freq_d = prm_q[`CSFS_PRM_MID];
      `CSFS_SEL_LOW: begin
        // Normal low speed keeps its full setting
        if (sel_cs_active && (low_prm > `CSFS_LOW_CLAMP)) begin
          freq_d = `CSFS_LOW_CLAMP;
        end else begin
          freq_d = low_prm;
        end
      end
      `CSFS_SEL_SP4:  freq_d = prm_q[`CSFS_PRM_SP4];
      `CSFS_SEL_SP5:  freq_d = prm_q[`CSFS_PRM_SP5];
      `CSFS_SEL_SP6:  freq_d = prm_q[`CSFS_PRM_SP6];
      `CSFS_SEL_SP7:  freq_d = prm_q[`CSFS_PRM_SP7];
      `CSFS_SEL_INCH: freq_d = prm_q[`CSFS_PRM_INCH];
      default:        freq_d = analog_freq_i;
    endcase
  end

  wire [15:0] stall2  = prm_q[`CSFS_PRM_STALL2];
  wire [15:0] cs_carr = prm_q[`CSFS_PRM_CS_CARRIER];
  wire [15:0] excit   = prm_q[`CSFS_PRM_EXCIT];

  wire [15:0] stall_d = (sel_cs_active && (stall2 != `CSFS_NOT_SET)) ?
                        stall2 : prm_q[`CSFS_PRM_STALL];
  // Carrier follows the present output frequency, not the command
  wire [15:0] carr_d  = (sel_cs_active && (output_freq_i <= `CSFS_CARRIER_FREQ) &&
                         (cs_carr != `CSFS_NOT_SET)) ?
                        cs_carr : prm_q[`CSFS_PRM_CARRIER];
  wire        exc_en_d = sel_cs_active && (excit != `CSFS_NOT_SET);
  // Out-of-range setting saturates rather than overdriving the motor
  wire [15:0] exc_d   = !exc_en_d ? 16'h0000 :
                        ((excit > `CSFS_EXCIT_MAX) ? `CSFS_EXCIT_MAX : excit);
  // Fast current limit would fight the holding torque at the stop
  wire        fast_lim_d = ~sel_cs_active;

  // ==========================================================
  // Registered commands to the drive core
  always @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      freq_cmd_o              <= 16'h0000;
      freq_src_o              <= `CSFS_SEL_ANALOG;
      contact_stop_active_o   <= 1'b0;
      stall_level_o           <= `CSFS_RST_PRM;
      carrier_o               <= `CSFS_RST_PRM;
      excit_comp_o            <= 16'h0000;
      excit_comp_en_o         <= 1'b0;
      fast_current_limit_en_o <= 1'b1;
    end else begin
      freq_cmd_o              <= freq_d;
      freq_src_o              <= sel_src;
      contact_stop_active_o   <= sel_cs_active;
      stall_level_o           <= stall_d;
      carrier_o               <= carr_d;
      excit_comp_o            <= exc_d;
      excit_comp_en_o         <= exc_en_d;
      fast_current_limit_en_o <= fast_lim_d;
    end
  end

  // ==========================================================
  // APB slave, one wait-free access phase
  // Slave never stalls, so a master may run transfers back to back
  assign pready = 1'b1;

  wire        setup    = psel && !penable;
  wire        wr_en    = psel && penable && pwrite;
  wire [AW-1:0] a      = paddr;
  wire        prm_hit  = (a >= `CSFS_OFS_PRM_FIRST) && (a <= `CSFS_OFS_PRM_LAST) &&
                         (a[1:0] == 2'b00);
  wire [AW-1:0] prm_off = a - `CSFS_OFS_PRM_FIRST;
  wire [3:0]  prm_idx  = prm_off[5:2];
  wire        word_hit = (a == `CSFS_OFS_ENABLE) || (a == `CSFS_OFS_MODE) ||
                         (a == `CSFS_OFS_SUPPR) || (a == `CSFS_OFS_TERM_LO) ||
                         (a == `CSFS_OFS_TERM_HI) || (a == `CSFS_OFS_STATUS);
  wire        mapped   = prm_hit || word_hit;

  // ==========================================================
  // Read multiplexer
  reg [31:0] rd_d;
  always @* begin
    rd_d = 32'h0000_0000;
    if (prm_hit) begin
      rd_d = {16'h0000, prm_q[prm_idx]};
    end else begin
      case (a)
        `CSFS_OFS_ENABLE: rd_d = {24'h000000, contact_stop_enable_param_q};
        `CSFS_OFS_MODE:   rd_d = {16'h0000, control_method_q, operation_mode_param_q};
        `CSFS_OFS_SUPPR:  rd_d = {8'h00, auto_accel_decel_param_q, pid_action_param_q,
                                  remote_setting_select_param_q};
        `CSFS_OFS_TERM_LO: rd_d = {term_fn_q[3], term_fn_q[2], term_fn_q[1], term_fn_q[0]};
        `CSFS_OFS_TERM_HI: rd_d = {8'h00, term_fn_q[6], term_fn_q[5], term_fn_q[4]};
        // Selection bits lag the pin levels by one edge
        `CSFS_OFS_STATUS: rd_d = {8'h00, {(16-NUM_TERM){1'b0}}, term_lvl,
                                  3'b000, contact_stop_active_o, freq_src_o};
        default:          rd_d = 32'h0000_0000;
      endcase
    end
  end

  // Read data and error latched in setup so the access phase sees flops
  always @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else if (setup) begin
      prdata  <= pwrite ? 32'h0000_0000 : rd_d;
      pslverr <= !mapped;
    end
  end

  // ==========================================================
  // Parameter writes, taken in the access phase only
  // Writes to the status word and to unused bytes are dropped
  always @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      contact_stop_enable_param_q   <= `CSFS_RST_ENABLE;
      operation_mode_param_q        <= `CSFS_RST_MODE_OP;
      control_method_q              <= `CSFS_RST_MODE_CTRL;
      remote_setting_select_param_q <= `CSFS_RST_SUPPR;
      pid_action_param_q            <= `CSFS_RST_SUPPR;
      auto_accel_decel_param_q      <= `CSFS_RST_SUPPR;
      for (i = 0; i < `CSFS_PRM_COUNT; i = i + 1) begin
        prm_q[i] <= `CSFS_RST_PRM;
      end
      for (i = 0; i < NUM_TERM; i = i + 1) begin
        term_fn_q[i] <= `CSFS_RST_TERM;
      end
    end else if (wr_en) begin
      if (prm_hit) begin
        prm_q[prm_idx] <= pwdata[15:0];
      end
      case (a)
        `CSFS_OFS_ENABLE: contact_stop_enable_param_q <= pwdata[7:0];
        `CSFS_OFS_MODE: begin
          operation_mode_param_q <= pwdata[`CSFS_MODE_OP_LSB +: 8];
          control_method_q       <= pwdata[`CSFS_MODE_CTRL_LSB +: 8];
        end
        `CSFS_OFS_SUPPR: begin
          remote_setting_select_param_q <= pwdata[`CSFS_SUPPR_REM_LSB +: 8];
          pid_action_param_q            <= pwdata[`CSFS_SUPPR_PID_LSB +: 8];
          auto_accel_decel_param_q      <= pwdata[`CSFS_SUPPR_AUTO_LSB +: 8];
        end
        `CSFS_OFS_TERM_LO: begin
          for (i = 0; i < 4; i = i + 1) begin
            if (i < NUM_TERM) begin
              term_fn_q[i] <= pwdata[i*8 +: 8];
            end
          end
        end
        `CSFS_OFS_TERM_HI: begin
          for (i = 4; i < NUM_TERM; i = i + 1) begin
            term_fn_q[i] <= pwdata[(i-4)*8 +: 8];
          end
        end
        default: ;
      endcase
    end
  end
endmodule // csfs_top
`default_nettype wire

// ---- testbench/csfs_top_sva.sv ----
// Port-level assertions for the contact-stop selection top
`timescale 1ns/10ps
`default_nettype none
module csfs_top_sva #(
  parameter NUM_TERM = 7,
  parameter AW       = 8
) (
  // Clock and reset
  input wire logic          ref_clk_i,
  input wire logic          rst_n_i,
  // APB
  input wire logic          psel,
  input wire logic          penable,
  input wire logic [AW-1:0] paddr,
  input wire logic          pready,
  input wire logic          pslverr,
  // Selection and drive-core commands
  input wire logic [15:0]   analog_freq_i,
  input wire logic [15:0]   freq_cmd_o,
  input wire logic [3:0]    freq_src_o,
  input wire logic          contact_stop_active_o,
  input wire logic [15:0]   excit_comp_o,
  input wire logic          excit_comp_en_o,
  input wire logic          fast_current_limit_en_o
);
  // ==========================================================
  // Checks
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!rst_n_i);

  a_fast_limit_off: assert property (fast_current_limit_en_o == !contact_stop_active_o)
    else $error("fast current limit not the inverse of contact-stop");
  a_active_low_src: assert property (contact_stop_active_o |-> freq_src_o == 4'h3)
    else $error("contact-stop active without low-speed source");
  a_low_clamp_cmd: assert property (contact_stop_active_o |-> freq_cmd_o <= 16'h0bb8)
    else $error("contact-stop command above 30 Hz");
  a_excit_cs_only: assert property (!contact_stop_active_o |->
                                    excit_comp_o == 16'h0000 && !excit_comp_en_o)
    else $error("excitation compensation outside contact-stop");
  a_excit_ceiling: assert property (excit_comp_o <= 16'h012c)
    else $error("excitation compensation above 300");
  a_inch_no_cs: assert property (freq_src_o == 4'h8 |-> !contact_stop_active_o)
    else $error("contact-stop active while inching selected");
  // Past reset guard: the first edge after release still shows reset values
  a_analog_follow: assert property ($past(rst_n_i) && freq_src_o == 4'h0 &&
                                    $stable(analog_freq_i) |-> freq_cmd_o == analog_freq_i)
    else $error("analog source not passed to frequency command");
  a_unmapped_err: assert property (psel && penable && pready && paddr > 8'h48 |-> pslverr)
    else $error("unmapped access without slave error");
endmodule // csfs_top_sva

bind csfs_top csfs_top_sva #(.NUM_TERM(NUM_TERM), .AW(AW)) u_sva (
  .ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .psel(psel), .penable(penable),
  .paddr(paddr), .pready(pready), .pslverr(pslverr), .analog_freq_i(analog_freq_i),
  .freq_cmd_o(freq_cmd_o), .freq_src_o(freq_src_o),
  .contact_stop_active_o(contact_stop_active_o), .excit_comp_o(excit_comp_o),
  .excit_comp_en_o(excit_comp_en_o), .fast_current_limit_en_o(fast_current_limit_en_o));
`default_nettype wire

// ---- testbench/csfs_term_model.sv ----
// Terminal switches and drive-core feedback seen by the selection block
`timescale 1ns/10ps
`default_nettype none
module csfs_term_model (
  // Clock
  input  wire logic        clk_i,
  // Requested switches: high, mid, low, second, inching
  input  wire logic [4:0]  sw_i,
  input  wire logic [15:0] analog_i,
  input  wire logic [15:0] outf_i,
  // Pins and feedback
  output var  logic [6:0]  term_pin_o,
  output var  logic [15:0] analog_freq_o,
  output var  logic [15:0] output_freq_o
);
  logic spare_q = 1'b0;
  initial begin
    term_pin_o    = 7'h00;
    analog_freq_o = 16'h0000;
    output_freq_o = 16'h0000;
  end
  // Spare terminals toggle every edge, so the pin filter keeps their levels low
  always @(posedge clk_i) begin
    spare_q       <= ~spare_q;
    term_pin_o    <= {spare_q, ~spare_q, sw_i[4], sw_i[3], sw_i[0], sw_i[1], sw_i[2]};
    analog_freq_o <= analog_i;
    output_freq_o <= outf_i;
  end
endmodule // csfs_term_model
`default_nettype wire

// ---- testbench/contact_stop_freq_select_tb.sv ----
// Self-checking bench for the contact-stop frequency selection top
`timescale 1ns/10ps
`default_nettype none
`include "csfs_defines.vh"
module contact_stop_freq_select_tb;
  // ==========================================================
  // Signals and model state
  logic        ref_clk_i = 1'b0;
  logic        rst_n_i   = 1'b0;
  logic        psel      = 1'b0;
  logic        penable   = 1'b0;
  logic        pwrite    = 1'b0;
  logic [7:0]  paddr     = 8'h00;
  logic [31:0] pwdata    = 32'h0;
  logic [4:0]  sw_q      = 5'h00;
  logic [15:0] ana_q     = 16'h0000;
  logic [15:0] outf_q    = 16'h0000;
  logic        pready, pslverr, cs_active, excit_en, fast_lim;
  logic [31:0] prdata;
  logic [6:0]  term_pin;
  logic [3:0]  freq_src;
  logic [15:0] analog_freq, output_freq, freq_cmd, stall_level, carrier, excit_comp;
  int errors = 0, checked = 0, seed = 47, cyc = 0, mapped = 0, cur = 0;
  int prm    [13] = '{1000, 1100, 4000, 1200, 1300, 1400, 1500, 500, 1500, 0, 100, 0, 0};
  int lut    [8]  = '{0, 1, 2, 6, 3, 5, 4, 7};
  int cf_en  [9]  = '{1, 2, 1, 1, 1, 1, 1, 1, 1};
  int cf_mode[9]  = '{'h100, 'h100, 'h101, 'h102, 'h300, 'h200, 'h200, 'h200, 'h200};
  int cf_sup [9]  = '{0, 0, 0, 0, 0, 3, 'h100, 'h10000, 4};
  int cf_st2 [9]  = '{1200, 1200, 1200, 1200, 1200, 1200, 1200, 1200, 9999};
  int cf_csc [9]  = '{50, 50, 50, 50, 50, 50, 50, 50, 9999};
  int cf_exc [9]  = '{400, 150, 150, 150, 150, 150, 150, 150, 9999};

  always #4 ref_clk_i = ~ref_clk_i;

  csfs_top #(.NUM_TERM(7), .AW(8)) dut (
    .ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
    .pslverr(pslverr), .term_pin_i(term_pin), .analog_freq_i(analog_freq),
    .output_freq_i(output_freq), .freq_cmd_o(freq_cmd), .freq_src_o(freq_src),
    .contact_stop_active_o(cs_active), .stall_level_o(stall_level), .carrier_o(carrier),
    .excit_comp_o(excit_comp), .excit_comp_en_o(excit_en),
    .fast_current_limit_en_o(fast_lim));

  csfs_term_model u_model (
    .clk_i(ref_clk_i), .sw_i(sw_q), .analog_i(ana_q), .outf_i(outf_q),
    .term_pin_o(term_pin), .analog_freq_o(analog_freq), .output_freq_o(output_freq));

  // ==========================================================
  // Tasks
  task automatic report_and_stop();
    $display("checked=%0d errors=%0d", checked, errors);
    if (errors == 0 && checked > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // Entered just after a rising edge; the pready wait is bounded only by the bench timeout
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] rd, output logic er);
    psel   <= 1'b1;
    pwrite <= wr;
    paddr  <= a;
    pwdata <= d;
    @(posedge ref_clk_i);
    penable <= 1'b1;
    @(posedge ref_clk_i);
    while (pready !== 1'b1) begin
      @(posedge ref_clk_i);
    end
    rd = prdata;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge ref_clk_i);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] rd;
    logic        er;
    apb(1'b1, a, d, rd, er);
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp, input logic experr);
    logic [31:0] rd;
    logic        er;
    apb(1'b0, a, 32'h0, rd, er);
    check("prdata", rd, exp);
    check("pslverr", 32'(er), 32'(experr));
  endtask

  task automatic set_cfg(input int c);
    cur = c;
    // Last config keeps low speed under the clamp
    prm[2]  = (c == 8) ? 250 : 4000;
    prm[9]  = cf_st2[c];
    prm[11] = cf_csc[c];
    prm[12] = cf_exc[c];
    for (int i = 0; i < 13; i++)
      wr(`CSFS_OFS_PRM_FIRST + 8'(4 * i), 32'(prm[i]));
    wr(`CSFS_OFS_ENABLE, 32'(cf_en[c]));
    wr(`CSFS_OFS_MODE, 32'(cf_mode[c]));
    wr(`CSFS_OFS_SUPPR, 32'(cf_sup[c]));
  endtask

  task automatic pins(input logic [4:0] s);
    int sel, fq, act, ok, rem, e, cr;
    logic [12:0] st;
    logic [4:0]  v;
    logic [31:0] rd;
    logic        er;
    v   = (mapped != 0) ? s : 5'h00;
    rem = cf_sup[cur] & 255;
    ok  = cf_en[cur] == 1 && (cf_mode[cur] & 255) == 0 && ((cf_mode[cur] >> 8) == 1 ||
          (cf_mode[cur] >> 8) == 2) && !(rem >= 1 && rem <= 3) && (cf_sup[cur] >> 8) == 0;
    act = ok && v[2] && v[3] && !v[4];
    sel = act ? 3 : lut[{v[2], v[1], v[0]}];
    if (v[4])
      sel = 8;
    sw_q   <= s;
    ana_q  <= 16'($random(seed));
    outf_q <= 16'h00fa + 16'($random(seed) & 63);
    repeat (8) @(posedge ref_clk_i);
    @(negedge ref_clk_i);
    fq = (sel == 0) ? int'(ana_q) : prm[sel - 1];
    if (act && fq > 3000)
      fq = 3000;
    e = act && prm[12] != 9999;
    cr = (act && outf_q <= 300 && prm[11] != 9999) ? prm[11] : prm[10];
    check("freq_src", 32'(freq_src), 32'(sel));
    check("freq_cmd", 32'(freq_cmd), 32'(fq));
    check("cs_active", 32'(cs_active), 32'(act));
    check("fast_limit", 32'(fast_lim), 32'(!act));
    check("stall", 32'(stall_level), 32'(act && prm[9] != 9999 ? prm[9] : prm[8]));
    check("carrier", 32'(carrier), 32'(cr));
    check("excit", 32'(excit_comp), 32'(e ? (prm[12] > 300 ? 300 : prm[12]) : 0));
    check("excit_en", 32'(excit_en), 32'(e));
    @(posedge ref_clk_i);
    apb(1'b0, `CSFS_OFS_STATUS, 32'h0, rd, er);
    st = {s[4], s[3], s[0], s[1], s[2], 3'h0, 1'(act), 4'(sel)};
    check("status", rd & 32'h1fff, 32'(st));
  endtask

  // ==========================================================
  // Timeout and main sequence
  always @(posedge ref_clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      errors++;
      report_and_stop();
    end
  end

  initial begin
    repeat (4) @(posedge ref_clk_i);
    rst_n_i <= 1'b1;
    @(posedge ref_clk_i);
    rd_chk(`CSFS_OFS_ENABLE, 32'h0, 1'b0);
    rd_chk(`CSFS_OFS_TERM_LO, 32'hffffffff, 1'b0);
    rd_chk(`CSFS_OFS_TERM_HI, 32'h00ffffff, 1'b0);
    rd_chk(8'h4c, 32'h0, 1'b1);
    wr(`CSFS_OFS_PRM_FIRST + 8'h08, 32'hffff0fa0);
    rd_chk(`CSFS_OFS_PRM_FIRST + 8'h08, 32'h00000fa0, 1'b0);
    set_cfg(0);
    // Unassigned terminals must not reach the table
    pins(5'h0c);
    wr(`CSFS_OFS_TERM_LO, 32'h03020100);
    wr(`CSFS_OFS_TERM_HI, 32'h00ffff05);
    mapped = 1;
    for (int c = 0; c < 9; c++) begin
      set_cfg(c);
      for (int s = 0; s < 32; s++)
        pins(5'(s));
    end
    report_and_stop();
  end
endmodule // contact_stop_freq_select_tb
`default_nettype wire
